//--- hdl/cbu_pkg.sv
// Package: constants and types for the conditional branch unit
package cbu_pkg;
    // ==========================================================
    // Widths
    localparam int CBU_PC_W = 16;
    localparam int CBU_K_W = 7;
    localparam int CBU_SREG_W = 8;
    // ==========================================================
    // Status flag positions
    localparam int CBU_C_POS = 0;
    localparam int CBU_Z_POS = 1;
    localparam int CBU_N_POS = 2;
    localparam int CBU_V_POS = 3;
    localparam int CBU_S_POS = 4;
    localparam int CBU_H_POS = 5;
    localparam int CBU_T_POS = 6;
    localparam int CBU_I_POS = 7;
    // ==========================================================
    // Reset values and PC increment constant
    localparam logic [15:0] CBU_PC_RST = 16'h0000;
    localparam logic [15:0] CBU_PC_ONE = 16'h0001;
    localparam logic [7:0] CBU_SREG_RST = 8'h00;
    // ==========================================================
    // Branch condition select codes
    typedef enum logic [3:0] {
        CBU_BR_SAME_OR_HIGHER = 4'h0,
        CBU_BR_LOWER = 4'h1,
        CBU_BR_NEGATIVE = 4'h2,
        CBU_BR_POSITIVE = 4'h3,
        CBU_BR_SIGNED_GE = 4'h4,
        CBU_BR_SIGNED_LT = 4'h5,
        CBU_BR_HALFCARRY_SET = 4'h6,
        CBU_BR_HALFCARRY_CLEAR = 4'h7,
        CBU_BR_TRANSFER_BIT_SET = 4'h8
    } cbu_cond_t;
    // ==========================================================
    // Execution states
    typedef enum logic [1:0] {
        CBU_ST_IDLE = 2'b01,
        CBU_ST_TAKEN = 2'b10
    } cbu_state_t;
endpackage

//--- hdl/cbu_cond_eval.sv
// Module: combinational branch condition evaluator
module cbu_cond_eval
    import cbu_pkg::*;
(
    input wire logic [3:0] condSel,
    input wire logic [CBU_SREG_W-1:0] sregIn,
    output logic condTrue,
    output logic condLegal
);
    logic flagC;
    logic flagN;
    logic flagV;
    logic flagH;
    logic flagT;

    assign flagC = sregIn[CBU_C_POS];
    assign flagN = sregIn[CBU_N_POS];
    assign flagV = sregIn[CBU_V_POS];
    assign flagH = sregIn[CBU_H_POS];
    assign flagT = sregIn[CBU_T_POS];

    always_comb begin
        condTrue = 1'b0;
        condLegal = 1'b1;
        case (condSel)
            CBU_BR_SAME_OR_HIGHER: condTrue = (flagC == 1'b0);
            CBU_BR_LOWER: condTrue = (flagC == 1'b1);
            CBU_BR_NEGATIVE: condTrue = (flagN == 1'b1);
            CBU_BR_POSITIVE: condTrue = (flagN == 1'b0);
            CBU_BR_SIGNED_GE: condTrue = ((flagN ^ flagV) == 1'b0);
            CBU_BR_SIGNED_LT: condTrue = ((flagN ^ flagV) == 1'b1);
            CBU_BR_HALFCARRY_SET: condTrue = (flagH == 1'b1);
            CBU_BR_HALFCARRY_CLEAR: condTrue = (flagH == 1'b0);
            CBU_BR_TRANSFER_BIT_SET: condTrue = (flagT == 1'b1);
            default: condLegal = 1'b0;
        endcase
    end
endmodule

//--- hdl/cbu_branch_unit.sv
// Module: conditional relative branch execution unit
//
// Overview of operation
// - Same-or-higher branches when carry is zero
// - Lower branches when carry is one
// - Negative branches on N one, positive on zero
// - Signed-ge branches when N xor V zero
// - Signed-lt branches when N xor V one
// - Half-carry-set branches when H is one
// - Half-carry-clear branches when H is zero
// - Transfer-bit-set branches when T is one
// - Taken branch loads PC plus k plus one
// - One cycle not taken, two cycles taken
// - Status flags never change
module cbu_branch_unit
    import cbu_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic issueValid,
    input wire logic [3:0] condSel,
    input wire logic [CBU_K_W-1:0] offsetK,
    input wire logic [CBU_PC_W-1:0] pcIn,
    input wire logic [CBU_SREG_W-1:0] sregIn,
    output logic issueReady,
    output logic [CBU_PC_W-1:0] pcOut,
    output logic pcLoad,
    output logic [CBU_SREG_W-1:0] sregOut,
    output logic branchTaken,
    output logic illegalCond
);
    // ==========================================================
    // Condition evaluation
    logic condTrue;
    logic condLegal;

    cbu_cond_eval uEval (
        .condSel(condSel),
        .sregIn(sregIn),
        .condTrue(condTrue),
        .condLegal(condLegal)
    );

    // ==========================================================
    // Target computation
    logic [CBU_PC_W-1:0] offsetExt;
    logic [CBU_PC_W-1:0] seqPc;
    logic [CBU_PC_W-1:0] targetPc;

    assign offsetExt = {{(CBU_PC_W-CBU_K_W){offsetK[CBU_K_W-1]}}, offsetK};
    assign seqPc = pcIn + CBU_PC_ONE;
    assign targetPc = pcIn + offsetExt + CBU_PC_ONE;

    // ==========================================================
    // Sequencer
    cbu_state_t state_r;
    cbu_state_t state_nxt;
    logic [CBU_PC_W-1:0] pcOut_r;
    logic [CBU_PC_W-1:0] pcOut_nxt;
    logic pcLoad_r;
    logic pcLoad_nxt;
    logic taken_r;
    logic taken_nxt;
    logic illegal_r;
    logic illegal_nxt;
    logic [CBU_SREG_W-1:0] sregOut_r;
    logic [CBU_SREG_W-1:0] sregOut_nxt;
    logic accept;

    assign issueReady = (state_r == CBU_ST_IDLE);
    assign accept = issueValid && issueReady;

    always_comb begin
        state_nxt = state_r;
        pcOut_nxt = pcOut_r;
        pcLoad_nxt = 1'b0;
        taken_nxt = 1'b0;
        illegal_nxt = 1'b0;
        sregOut_nxt = sregIn;
        unique case (state_r)
            CBU_ST_IDLE: begin
                if (accept) begin
                    if (!condLegal) begin
                        illegal_nxt = 1'b1;
                        pcOut_nxt = seqPc;
                        pcLoad_nxt = 1'b1;
                    end else if (condTrue) begin
                        pcOut_nxt = targetPc;
                        state_nxt = CBU_ST_TAKEN;
                    end else begin
                        pcOut_nxt = seqPc;
                        pcLoad_nxt = 1'b1;
                    end
                end
            end
            CBU_ST_TAKEN: begin
                pcLoad_nxt = 1'b1;
                taken_nxt = 1'b1;
                state_nxt = CBU_ST_IDLE;
            end
            default: state_nxt = CBU_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= CBU_ST_IDLE;
            pcOut_r <= CBU_PC_RST;
            pcLoad_r <= 1'b0;
            taken_r <= 1'b0;
            illegal_r <= 1'b0;
            sregOut_r <= CBU_SREG_RST;
        end else begin
            state_r <= state_nxt;
            pcOut_r <= pcOut_nxt;
            pcLoad_r <= pcLoad_nxt;
            taken_r <= taken_nxt;
            illegal_r <= illegal_nxt;
            sregOut_r <= sregOut_nxt;
        end
    end

    assign pcOut = pcOut_r;
    assign pcLoad = pcLoad_r;
    assign branchTaken = taken_r;
    assign illegalCond = illegal_r;
    assign sregOut = sregOut_r;

    // ==========================================================
    // Assertions
    sequence s_takenIssue;
        accept && condLegal && condTrue;
    endsequence

    sequence s_notTakenIssue;
        accept && condLegal && !condTrue;
    endsequence

    a_taken_two_cycles: assert property (@(posedge clk) disable iff (reset)
        s_takenIssue |=> !pcLoad ##1 (pcLoad && branchTaken))
        else $error("taken branch not completed in two cycles");

    a_taken_target_pc: assert property (@(posedge clk) disable iff (reset)
        s_takenIssue |=> ##1 (pcOut == $past(pcIn, 2) + {{9{$past(offsetK[6], 2)}},
            $past(offsetK, 2)} + 16'h0001))
        else $error("taken branch target wrong");

    a_fail_one_cycle: assert property (@(posedge clk) disable iff (reset)
        s_notTakenIssue |=> (pcLoad && !branchTaken))
        else $error("untaken branch not completed in one cycle");

    a_fail_next_pc: assert property (@(posedge clk) disable iff (reset)
        s_notTakenIssue |=> (pcOut == $past(pcIn) + 16'h0001))
        else $error("untaken branch pc not sequential");

    a_busy_when_taken: assert property (@(posedge clk) disable iff (reset)
        s_takenIssue |=> !issueReady ##1 issueReady)
        else $error("ready wrong during taken branch");

    a_sreg_kept: assert property (@(posedge clk) disable iff (reset)
        accept |=> (sregOut == $past(sregIn)))
        else $error("status flags altered");

    a_carry_conds: assert property (@(posedge clk) disable iff (reset)
        (accept && condSel == 4'h0) |-> (condTrue == !sregIn[0]))
        else $error("same-or-higher condition wrong");

    a_lower_cond: assert property (@(posedge clk) disable iff (reset)
        (accept && condSel == 4'h1) |=> ##1 (branchTaken == $past(sregIn[0], 2)))
        else $error("lower condition wrong");

    a_sign_conds: assert property (@(posedge clk) disable iff (reset)
        (accept && condSel inside {4'h2, 4'h3}) |->
            (condTrue == (sregIn[2] ^ condSel[0])))
        else $error("negative or positive condition wrong");

    a_signed_ge: assert property (@(posedge clk) disable iff (reset)
        (accept && condSel == 4'h4) |-> (condTrue == !(sregIn[2] ^ sregIn[3])))
        else $error("signed ge condition wrong");

    a_signed_lt: assert property (@(posedge clk) disable iff (reset)
        (accept && condSel == 4'h5) |-> (condTrue == (sregIn[2] ^ sregIn[3])))
        else $error("signed lt condition wrong");

    a_halfcarry_set: assert property (@(posedge clk) disable iff (reset)
        (accept && condSel == 4'h6) |-> (condTrue == sregIn[5]))
        else $error("half carry set condition wrong");

    a_halfcarry_clr: assert property (@(posedge clk) disable iff (reset)
        (accept && condSel == 4'h7) |-> (condTrue == !sregIn[5]))
        else $error("half carry clear condition wrong");

    a_tbit_set: assert property (@(posedge clk) disable iff (reset)
        (accept && condSel == 4'h8) |-> (condTrue == sregIn[6]))
        else $error("transfer bit condition wrong");

    a_sign_extend: assert property (@(posedge clk) disable iff (reset)
        s_takenIssue |=> ##1 ((pcOut - $past(pcIn, 2) - 16'h0001) ==
            {{9{$past(offsetK[6], 2)}}, $past(offsetK, 2)}))
        else $error("offset not sign extended");

    a_illegal_seq: assert property (@(posedge clk) disable iff (reset)
        (accept && !condLegal) |=> (pcLoad && illegalCond && !branchTaken &&
            pcOut == $past(pcIn) + 16'h0001))
        else $error("illegal condition not advanced sequentially");

    a_load_source: assert property (@(posedge clk) disable iff (reset)
        pcLoad |-> ($past(accept && !(condLegal && condTrue)) ||
            $past(state_r == CBU_ST_TAKEN)))
        else $error("program counter load without a branch");

    a_taken_with_load: assert property (@(posedge clk) disable iff (reset)
        branchTaken |-> (pcLoad && !illegalCond))
        else $error("taken pulse without load");

    a_ready_recovers: assert property (@(posedge clk) disable iff (reset)
        !issueReady |=> issueReady)
        else $error("busy longer than one cycle");

    a_pc_held: assert property (@(posedge clk) disable iff (reset)
        !accept |=> $stable(pcOut))
        else $error("program counter changed without a branch");
endmodule

//--- bench/cbu_branch_unit_tb.sv
// Testbench for the conditional branch unit
module cbu_branch_unit_tb import cbu_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic issueValid = 1'b0;
    logic [3:0] condSel = 4'h0;
    logic [CBU_K_W-1:0] offsetK = 7'h00;
    logic [CBU_PC_W-1:0] pcIn = 16'h0000;
    logic [CBU_SREG_W-1:0] sregIn = 8'h00;
    logic issueReady, pcLoad, branchTaken, illegalCond;
    logic [CBU_PC_W-1:0] pcOut;
    logic [CBU_SREG_W-1:0] sregOut;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] pats [7] = '{8'h00, 8'hFF, 8'h04, 8'h08, 8'h01, 8'h20, 8'h40};
    cbu_branch_unit uut (.clk(clk), .reset(reset), .issueValid(issueValid),
        .condSel(condSel), .offsetK(offsetK), .pcIn(pcIn), .sregIn(sregIn),
        .issueReady(issueReady), .pcOut(pcOut), .pcLoad(pcLoad), .sregOut(sregOut),
        .branchTaken(branchTaken), .illegalCond(illegalCond));
    // ==========================================================
    // Clock, timeout and checking
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic logic holds(input logic [3:0] c, input logic [7:0] s);
        case (c)
            4'h0: return !s[CBU_C_POS];
            4'h1: return s[CBU_C_POS];
            4'h2: return s[CBU_N_POS];
            4'h3: return !s[CBU_N_POS];
            4'h4: return !(s[CBU_N_POS] ^ s[CBU_V_POS]);
            4'h5: return s[CBU_N_POS] ^ s[CBU_V_POS];
            4'h6: return s[CBU_H_POS];
            4'h7: return !s[CBU_H_POS];
            4'h8: return s[CBU_T_POS];
            default: return 1'b0;
        endcase
    endfunction
    // ==========================================================
    // Scenarios
    task automatic run_branch(input logic [3:0] c, input logic [6:0] k, input logic [15:0] pc,
        input logic [7:0] s);
        logic tk;
        tk = holds(c, s);
        @(posedge clk);
        issueValid <= 1'b1;
        condSel <= c;
        offsetK <= k;
        pcIn <= pc;
        sregIn <= s;
        @(posedge clk);
        issueValid <= 1'b0;
        sregIn <= ~s;
        #1;
        check("sregOut", {8'h00, sregOut}, {8'h00, s});
        check("pcLoad", pcLoad, !tk);
        if (!tk) begin
            check("pcOut seq", pcOut, pc + 16'h0001);
            check("branchTaken", branchTaken, 1'b0);
            check("illegalCond", illegalCond, c > 4'h8);
        end else begin
            check("issueReady", issueReady, 1'b0);
            @(posedge clk);
            #1;
            check("pcLoad taken", pcLoad, 1'b1);
            check("branchTaken", branchTaken, 1'b1);
            check("pcOut target", pcOut, pc + {{9{k[6]}}, k} + 16'h0001);
        end
    endtask
    task automatic test_all_conds;
        for (int c = 0; c < 16; c++) begin
            for (int p = 0; p < 7; p++) begin
                run_branch(c[3:0], 7'(c * 9 + p), 16'(c * 16'h0100 + p), pats[p]);
            end
        end
    endtask
    task automatic test_offsets;
        run_branch(4'h8, 7'h3F, 16'hFFF0, 8'h40);
        run_branch(4'h8, 7'h40, 16'h0010, 8'h40);
        run_branch(4'h8, 7'h7F, 16'h0000, 8'h40);
        run_branch(4'h0, 7'h00, 16'hFFFF, 8'h00);
        run_branch(4'h1, 7'h00, 16'hFFFF, 8'h00);
    endtask
    task automatic test_back_to_back;
        @(posedge clk);
        issueValid <= 1'b1;
        condSel <= 4'h1;
        sregIn <= 8'h00;
        pcIn <= 16'h1000;
        @(posedge clk);
        pcIn <= 16'h2000;
        @(posedge clk);
        issueValid <= 1'b0;
        #1;
        check("pcLoad b2b", pcLoad, 1'b1);
        check("pcOut b2b", pcOut, 16'h2001);
    endtask
    task automatic test_refused;
        @(posedge clk);
        issueValid <= 1'b1;
        condSel <= 4'h2;
        sregIn <= 8'h04;
        offsetK <= 7'h05;
        pcIn <= 16'h0300;
        @(posedge clk);
        condSel <= 4'h3;
        pcIn <= 16'h0500;
        @(posedge clk);
        #1;
        check("pcOut taken", pcOut, 16'h0306);
        check("pcLoad taken", pcLoad, 1'b1);
        @(posedge clk);
        issueValid <= 1'b0;
        #1;
        check("pcLoad held", pcLoad, 1'b1);
        check("pcOut next", pcOut, 16'h0501);
        check("branchTaken next", branchTaken, 1'b0);
        @(posedge clk);
        #1;
        check("pcLoad ignored", pcLoad, 1'b0);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        #1;
        check("pcOut reset", pcOut, 16'h0000);
        check("issueReady reset", issueReady, 1'b1);
        @(posedge clk);
        reset <= 1'b0;
        test_all_conds();
        test_offsets();
        test_back_to_back();
        test_refused();
        tally_and_finish();
    end
endmodule
